// ### src/rdoi_top.sv
// Purpose: Receive data output interface with APB registers.
// Assumes: Demodulator inputs are synchronous to pclk.
// Notes:   Buffer is 32 bits; a read word holds its low 24 bits above the status byte.

`timescale 1ns/10ps
`default_nettype none

module rdoi_top #(
   parameter int BUF_BITS = 32 // Payload buffer depth in bits
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire rdoi_pkg::rdoi_demod_t demod,
   output rdoi_pkg::rdoi_pins_t      pins,
   output logic                      alert_out_n,
   output logic      [1:0]           active_set
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [31:0]             control;   // Mode, wake, set fields
   logic [2:0]              pincfg;    // Polarities
   logic [3:0]              alerten;   // Alert enables
   logic [3:0]              events;    // Sticky event flags
   logic [15:0]             tickdiv;   // Timebase divider
   logic [11:0]             setcfg;    // Three bits per set
   logic [BUF_BITS-1:0]     buf_bits;  // Payload store
   logic [5:0]              buf_cnt;   // Valid bits
   logic                    buf_ovf;   // Overflow seen
   logic                    pkt_ready; // Packet complete

   // Bus decode
   wire        acc      = psel & penable;
   wire        wr       = acc & pwrite;
   wire        rd       = acc & ~pwrite;
   wire        hit_ctl  = (paddr == rdoi_pkg::OFS_CONTROL);
   wire        hit_pin  = (paddr == rdoi_pkg::OFS_PINCFG);
   wire        hit_aen  = (paddr == rdoi_pkg::OFS_ALERTEN);
   wire        hit_sts  = (paddr == rdoi_pkg::OFS_STATUS);
   wire        hit_buf  = (paddr == rdoi_pkg::OFS_BUFDATA);
   wire        hit_div  = (paddr == rdoi_pkg::OFS_TICKDIV);
   wire        hit_set  = (paddr == rdoi_pkg::OFS_SETCFG);
   wire        mapped   = hit_ctl | hit_pin | hit_aen | hit_sts |
                          hit_buf | hit_div | hit_set;

   // Mode and wake-up selection
   wire logic [2:0] mode_raw  = control[rdoi_pkg::CTL_MODE_LSB +: 3];
   wire logic [1:0] wake_raw  = control[rdoi_pkg::CTL_WAKE_LSB +: 2];
   wire logic       auto_rot  = control[rdoi_pkg::CTL_AUTO_BIT];
   wire logic [2:0] set_mode  = setcfg[active_set*3 +: 3];
   wire logic [2:0] mode_sel  = auto_rot ? set_mode : mode_raw;
   // Codes above four fall back to buffer mode
   wire logic       mode_ok   = (mode_sel <= 3'h4);
   wire rdoi_pkg::rdoi_mode_t mode =
      mode_ok ? rdoi_pkg::rdoi_mode_t'(mode_sel) : rdoi_pkg::RDOI_PACKET_BUFFER;

   // Filter modes allow only level RSSI; chip mode forbids pattern
   wire logic wake_ok =
      (mode == rdoi_pkg::RDOI_MATCHED_FILT || mode == rdoi_pkg::RDOI_RAW_SLICER)
         ? (wake_raw == rdoi_pkg::RDOI_WAKE_RSSI)
         : (mode == rdoi_pkg::RDOI_CHIP_STROBE)
            ? (wake_raw != rdoi_pkg::RDOI_WAKE_PATTERN)
            : 1'b1;

   wire logic rx_on = demod.active & wake_ok;

   ////////////////////////////////////////////////////////////////////////////
   // APB writes and register state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control <= rdoi_pkg::RST_CONTROL;
         pincfg  <= rdoi_pkg::RST_PINCFG;
         alerten <= rdoi_pkg::RST_ALERTEN;
         tickdiv <= rdoi_pkg::RST_TICKDIV;
         setcfg  <= 12'h000;
      end else if (wr) begin
         if (hit_ctl) control <= pwdata;
         if (hit_pin) pincfg  <= pwdata[2:0];
         if (hit_aen) alerten <= pwdata[3:0];
         if (hit_div) tickdiv <= pwdata[15:0];
         if (hit_set) setcfg  <= pwdata[11:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Autonomous configuration set rotation at end of each receive phase
   logic active_d;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_d   <= 1'b0;
         active_set <= 2'h0;
      end else begin
         active_d <= demod.active;
         if (!auto_rot)
            active_set <= control[rdoi_pkg::CTL_SET_LSB +: 2];
         else if (active_d && !demod.active)
            active_set <= active_set + 2'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Payload buffer, packet modes only
   wire logic pkt_mode  = (mode == rdoi_pkg::RDOI_PACKET_BUFFER) ||
                          (mode == rdoi_pkg::RDOI_PAYLOAD_PIN);
   // Headers and wake-up frames are dropped here
   wire logic buf_wr    = rx_on & pkt_mode & demod.bit_valid &
                          demod.payload;
   // Emptied at the setup edge that captures the word, so a bit landing
   // between setup and access stays for the next read
   wire logic buf_rd    = psel & ~penable & ~pwrite & hit_buf;
   wire logic buf_full  = (buf_cnt == 6'(BUF_BITS));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buf_bits <= '0;
         buf_cnt  <= 6'h00;
         buf_ovf  <= 1'b0;
      end else if (buf_rd) begin
         // A read empties the store; a bit landing now starts the next one
         buf_bits <= buf_wr ? BUF_BITS'(demod.bit_val) : '0;
         buf_cnt  <= buf_wr ? 6'h01 : 6'h00;
         buf_ovf  <= 1'b0;
      end else if (buf_wr) begin
         if (buf_full) begin
            buf_ovf <= 1'b1;
         end else begin
            buf_bits[buf_cnt[4:0]] <= demod.bit_val;
            buf_cnt <= buf_cnt + 6'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Events: packet ready, overflow, frame end, receiver start
   wire logic [3:0] ev_set = {rx_on & ~active_d,
                              rx_on & demod.frame_end,
                              buf_wr & buf_full,
                              rx_on & pkt_mode & demod.frame_end};
   wire logic       sts_rd = rd & hit_sts;

   // Set wins over a read clear in the same cycle; a read clears only the
   // flags shown in its captured word, so a late event is not lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         events    <= 4'h0;
         pkt_ready <= 1'b0;
      end else begin
         events    <= (sts_rd ? events & ~prdata[3:0] : events) |
                      ev_set;
         pkt_ready <= (buf_rd ? 1'b0 : pkt_ready) | ev_set[0];
      end
   end

   // Dedicated alert pin, polarity selectable, default active low
   wire logic alert_act = |(events & alerten);
   wire logic alert_hi  = pincfg[rdoi_pkg::PIN_ALRT_BIT];
   assign alert_out_n = alert_hi ? alert_act : ~alert_act;

   ////////////////////////////////////////////////////////////////////////////
   // Read data, only in answer to an access
   wire logic [7:0] stat_word = {buf_ovf, 1'b0, buf_cnt};
   wire logic [31:0] rd_mux =
      hit_ctl ? control :
      hit_pin ? {29'h0, pincfg} :
      hit_aen ? {28'h0, alerten} :
      hit_sts ? {27'h0, pkt_ready, events} :
      hit_buf ? {buf_bits[23:0], stat_word} :
      hit_div ? {16'h0, tickdiv} :
      hit_set ? {20'h0, setcfg} : 32'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
         prdata <= rd_mux;
   end

   // Data stays stable through access; buffer read shows status from before the pop
   assign pready  = 1'b1;
   assign pslverr = acc & ~mapped;

   ////////////////////////////////////////////////////////////////////////////
   // Timebase: sixteen ticks per bit or chip period
   logic [15:0] div_cnt;
   logic [3:0]  phase;
   logic        last_bit;
   logic        pdata;
   logic        chip_d;   // Chip stream delayed to match the phase count
   wire logic   tick     = (div_cnt >= tickdiv - 16'h0001);
   wire logic   restart  = (mode == rdoi_pkg::RDOI_PAYLOAD_PIN) ?
                           buf_wr : demod.chip_edge;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt <= 16'h0000;
         phase   <= 4'h0;
      end else if (restart) begin
         div_cnt <= 16'h0000;
         phase   <= 4'h0;
      end else if (tick) begin
         div_cnt <= 16'h0000;
         phase   <= (phase == 4'hF) ? phase : phase + 4'h1;
      end else begin
         div_cnt <= div_cnt + 16'h0001;
      end
   end

   // Decoded payload bit held until the next one; chip stream delayed one
   // clock so the pin changes as the restarted phase counts from zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_bit <= 1'b0;
         chip_d   <= 1'b0;
      end else begin
         chip_d <= demod.chip;
         if (buf_wr)
            last_bit <= demod.bit_val;
      end
   end

   wire logic pstr_win = (phase >= rdoi_pkg::PSTR_START) &&
                         (phase <  rdoi_pkg::PSTR_STOP);
   wire logic cstr_win = (phase >= rdoi_pkg::CSTR_START) &&
                         (phase <  rdoi_pkg::CSTR_STOP);

   // Output pin values per mode; all low while inactive
   wire logic pp_on = rx_on & (mode == rdoi_pkg::RDOI_PAYLOAD_PIN);
   wire logic cs_on = rx_on & (mode == rdoi_pkg::RDOI_CHIP_STROBE);
   wire logic mf_on = rx_on & (mode == rdoi_pkg::RDOI_MATCHED_FILT);
   wire logic rs_on = rx_on & (mode == rdoi_pkg::RDOI_RAW_SLICER);

   ////////////////////////////////////////////////////////////////////////////
   // Registered pins; buffer mode drives none of them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pins <= '0;
      end else begin
         pins.payload_data_out   <= pp_on & last_bit;
         pins.payload_strobe_out <= pp_on &
            (pstr_win ^ pincfg[rdoi_pkg::PIN_PSTR_BIT]);
         pins.chip_data_out      <= cs_on & chip_d;
         pins.chip_strobe_out    <= cs_on &
            (cstr_win ^ pincfg[rdoi_pkg::PIN_CSTR_BIT]);
         pins.matched_filter_out <= mf_on & demod.mf2_sign;
         pins.raw_data_out       <= rs_on & demod.mf1_data;
      end
   end
   // Buffer mode leaves all pins at zero, data only over the bus

endmodule

`default_nettype wire

// ### src/rdoi_pkg.sv
// Purpose: Shared constants and types for the receiver data output block.
// Assumes: APB slave, 32-bit words, byte addresses on word boundaries.
// Notes:   Functional notes follow.

package rdoi_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] OFS_CONTROL = 8'h00; // Mode, set select, wake-up
   localparam logic [7:0] OFS_PINCFG  = 8'h04; // Strobe and alert polarity
   localparam logic [7:0] OFS_ALERTEN = 8'h08; // Alert source enables
   localparam logic [7:0] OFS_STATUS  = 8'h0C; // Event flags, read clears
   localparam logic [7:0] OFS_BUFDATA = 8'h10; // Buffer pop with status
   localparam logic [7:0] OFS_TICKDIV = 8'h14; // Clocks per timebase tick
   localparam logic [7:0] OFS_SETCFG  = 8'h18; // Mode per config set

   // Field positions
   localparam int CTL_MODE_LSB = 0;  // 3-bit mode
   localparam int CTL_WAKE_LSB = 4;  // 2-bit wake-up criterion
   localparam int CTL_SET_LSB  = 8;  // 2-bit active set
   localparam int CTL_AUTO_BIT = 12; // Autonomous set rotation
   localparam int PIN_PSTR_BIT = 0;  // Payload strobe inverted
   localparam int PIN_CSTR_BIT = 1;  // Chip strobe inverted
   localparam int PIN_ALRT_BIT = 2;  // Alert active high

   // Reset values
   localparam logic [31:0] RST_CONTROL = 32'h0000_0000;
   localparam logic [2:0]  RST_PINCFG  = 3'h0;
   localparam logic [3:0]  RST_ALERTEN = 4'h1;
   localparam logic [15:0] RST_TICKDIV = 16'h0001;

   // Strobe placement in sixteenths of a period
   localparam logic [3:0] PSTR_START = 4'h1; // Tbit/16
   localparam logic [3:0] PSTR_STOP  = 4'h9; // plus Tbit/2
   localparam logic [3:0] CSTR_START = 4'h2; // Tchip/8
   localparam logic [3:0] CSTR_STOP  = 4'hA; // plus Tchip/2

   // Status word fields
   localparam int STW_OVF_BIT = 7;

   // Receive modes
   typedef enum logic [2:0] {
      RDOI_PACKET_BUFFER = 3'h0,
      RDOI_PAYLOAD_PIN   = 3'h1,
      RDOI_CHIP_STROBE   = 3'h2,
      RDOI_MATCHED_FILT  = 3'h3,
      RDOI_RAW_SLICER    = 3'h4
   } rdoi_mode_t;

   // Wake-up criteria
   typedef enum logic [1:0] {
      RDOI_WAKE_RSSI    = 2'h0,
      RDOI_WAKE_SIGNAL  = 2'h1,
      RDOI_WAKE_SYNC    = 2'h2,
      RDOI_WAKE_PATTERN = 2'h3
   } rdoi_wake_t;

   // Demodulator side inputs
   typedef struct packed {
      logic active;      // Receiver in a receive phase
      logic chip;        // Line-encoded chip stream
      logic chip_edge;   // One-cycle mark of each chip start
      logic bit_valid;   // Decoded bit pulse
      logic bit_val;     // Decoded bit value
      logic payload;     // Bit belongs to payload, not headers
      logic frame_end;   // End of message pulse
      logic mf2_sign;    // Two-chip matched filter sign
      logic mf1_data;    // One-chip matched filter data
   } rdoi_demod_t;

   // Pin outputs
   typedef struct packed {
      logic payload_data_out;
      logic payload_strobe_out;
      logic chip_data_out;
      logic chip_strobe_out;
      logic matched_filter_out;
      logic raw_data_out;
   } rdoi_pins_t;

endpackage

// ### tb/rdoi_monitor.sv
// Purpose: Port assertions for the receive data output block.
// Assumes: TICKDIV stays at one, so one tick is one pclk.
// Notes:   Mode and polarity are shadowed from APB writes.
`timescale 1ns/10ps
`default_nettype none
module rdoi_monitor #(
   parameter int BUF_BITS = 32 // Buffer depth, mirrored from the design
) (
   input wire logic                  pclk,
   input wire logic                  presetn,
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [7:0]            paddr,
   input wire logic [31:0]           pwdata,
   input wire logic [31:0]           prdata,
   input wire logic                  pready,
   input wire logic                  pslverr,
   input wire rdoi_pkg::rdoi_demod_t demod,
   input wire rdoi_pkg::rdoi_pins_t  pins,
   input wire logic                  alert_out_n,
   input wire logic [1:0]            active_set
);
   logic [12:0] ctl_q; // Shadow of CONTROL
   logic [1:0]  pol_q; // Shadow of strobe inversion bits
   wire logic wr  = psel && penable && pwrite;
   wire logic hit = paddr <= 8'h18 && paddr[1:0] == 2'h0;
   wire logic [2:0] md = ctl_q[2:0];
   // Legal wake-up, no rotation, set zero: only then is the mode known
   wire logic ok = ctl_q[12:4] == 9'h000 && active_set == 2'h0 && demod.active;
   wire logic ps = pins.payload_strobe_out ^ pol_q[0];
   wire logic cs = pins.chip_strobe_out ^ pol_q[1];
   //////////////////////////////////////////////////////////////////////////
   // Shadow registers follow the write edge of the bus
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_q <= 13'h0000;
         pol_q <= 2'h0;
      end else if (wr && paddr == rdoi_pkg::OFS_CONTROL) begin
         ctl_q <= pwdata[12:0];
      end else if (wr && paddr == rdoi_pkg::OFS_PINCFG) begin
         pol_q <= pwdata[1:0];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   //////////////////////////////////////////////////////////////////////////
   a_ready_high: assert property (pready)
      else $error("pready dropped");
   a_unmapped_err: assert property (
      psel && penable |-> pslverr == !hit) else $error("pslverr wrong");
   a_idle_low: assert property (
      (!demod.active && pol_q == 2'h0) [*3] |-> pins == '0)
      else $error("pins not low while idle");
   // With rotation on, the mode comes from the set table, not from md
   a_buffer_quiet: assert property (
      (md == 3'h0 && !ctl_q[12]) [*2] |-> pins == '0)
      else $error("pin active in buffer mode");
   // Bit is latched one clock after it arrives, pin follows one later
   a_pay_data: assert property (
      ok && md == 3'h1 && demod.bit_valid && demod.payload
      |-> ##2 pins.payload_data_out == $past(demod.bit_val, 2))
      else $error("payload data pin wrong");
   a_pstr_shape: assert property (
      ok && md == 3'h1 && demod.bit_valid && demod.payload
      |=> !ps [*2] ##1 ps [*8] ##1 !ps)
      else $error("payload strobe misplaced");
   a_cstr_shape: assert property (
      ok && md == 3'h2 && demod.chip_edge
      |=> !cs [*3] ##1 cs [*8] ##1 !cs)
      else $error("chip strobe misplaced");
   a_chip_follow: assert property (
      ok && $past(demod.active) && md == 3'h2
      |=> pins.chip_data_out == $past(demod.chip, 2))
      else $error("chip pin wrong");
   a_mf_sign: assert property (
      ok && $past(demod.active) && md == 3'h3
      |=> pins.matched_filter_out == $past(demod.mf2_sign))
      else $error("filter sign pin wrong");
   a_raw_follow: assert property (
      ok && $past(demod.active) && md == 3'h4
      |=> pins.raw_data_out == $past(demod.mf1_data)) else $error("raw pin wrong");
   c_pstr: cover property (ok && md == 3'h1 && demod.bit_valid);
   c_cstr: cover property (ok && md == 3'h2 && demod.chip_edge);
   c_bufrd: cover property (psel && penable && paddr == rdoi_pkg::OFS_BUFDATA);
endmodule
bind rdoi_top rdoi_monitor #(.BUF_BITS(BUF_BITS)) u_mon (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .demod(demod), .pins(pins),
   .alert_out_n(alert_out_n), .active_set(active_set));
`default_nettype wire

// ### tb/rdoi_demod_model.sv
// Purpose: Demodulator stand-in that sends one framed burst on request.
// Assumes: One bit and one chip every PER clocks.
// Notes:   Header bits are zero and payload bits one; idle lines wobble.
`timescale 1ns/10ps
`default_nettype none
module rdoi_demod_model #(
   parameter int PER = 16 // Clocks per bit and per chip
) (
   input  wire logic            pclk,
   input  wire logic            presetn,
   input  wire logic            start,    // Begin one frame
   input  wire logic [5:0]      hdr_bits, // Header bits, must be stripped
   input  wire logic [5:0]      pay_bits, // Payload bits
   output var rdoi_pkg::rdoi_demod_t demod,
   output logic                 busy
);
   logic [4:0] cnt; // Clock within a bit
   logic [6:0] n;   // Bits already sent
   wire logic tick = busy && cnt == 5'(PER - 1);
   wire logic last = n == {1'b0, hdr_bits} + {1'b0, pay_bits};
   // First edge lands a full period after start, so active leads it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         demod <= '0;
         busy <= 1'b0;
         cnt <= 5'h00;
         n <= 7'h00;
      end else begin
         cnt <= tick ? 5'h00 : cnt + 5'h01;
         demod.active <= busy;
         demod.chip_edge <= tick && !last;
         demod.bit_valid <= tick && !last;
         demod.frame_end <= tick && last;
         demod.mf2_sign <= ~demod.mf2_sign; // Never rests, so gating shows
         demod.mf1_data <= cnt[1];
         if (!busy) demod.chip <= ~demod.chip;
         if (tick && !last) begin
            demod.chip <= ~demod.chip;
            demod.payload <= n >= {1'b0, hdr_bits};
            demod.bit_val <= n >= {1'b0, hdr_bits};
            n <= n + 7'h01;
         end
         if (tick && last) busy <= 1'b0;
         if (start && !busy) begin
            busy <= 1'b1;
            n <= 7'h00;
            cnt <= 5'h00;
         end
      end
   end
endmodule
`default_nettype wire

// ### tb/test_receiver_data_output_interface.sv
// Purpose: Self-checking bench for the receive data output block.
// Assumes: Two header and four payload bits per frame, TICKDIV at one.
// Notes:   Strobe shapes are judged by the bound monitor.
`timescale 1ns/10ps
`default_nettype none
module test_receiver_data_output_interface;
   logic        pclk = 1'b0, presetn = 1'b0, start = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, alert_out_n, busy, err;
   logic [1:0]  active_set;
   rdoi_pkg::rdoi_demod_t demod;
   rdoi_pkg::rdoi_pins_t  pins;
   logic [2:0]  bad_md [3] = '{3'h2, 3'h3, 3'h4}; // Mode with a
   logic [1:0]  bad_wk [3] = '{2'h3, 2'h1, 2'h2}; // forbidden wake-up
   int n_errors = 0, check_count = 0, ps_hi, cs_hi, any_hi;
   always #20 pclk = ~pclk;
   rdoi_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .demod(demod),
      .pins(pins), .alert_out_n(alert_out_n), .active_set(active_set));
   rdoi_demod_model #(.PER(16)) u_src (.pclk(pclk), .presetn(presetn),
      .start(start), .hdr_bits(6'h02), .pay_bits(6'h04), .demod(demod),
      .busy(busy));
   //////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         n_errors++;
         tally_and_finish;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   // Send one frame and count strobe and pin activity, bounded
   task automatic frame;
      int k;
      int t;
      ps_hi = 0;
      cs_hi = 0;
      any_hi = 0;
      @(posedge pclk);
      start <= 1'b1;
      @(posedge pclk);
      start <= 1'b0;
      t = 0;
      for (k = 0; t < 16; k++) begin
         @(negedge pclk);
         ps_hi += int'(pins.payload_strobe_out);
         cs_hi += int'(pins.chip_strobe_out);
         any_hi += int'(|pins);
         t = (busy === 1'b1) ? 0 : t + 1;
         if (k == 400) begin
            n_errors++;
            tally_and_finish;
         end
      end
   endtask
   //////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk(32'(alert_out_n), 32'h1);
      chk(32'(pins), 32'h0);
      rd_chk(rdoi_pkg::OFS_CONTROL, 32'h0);
      rd_chk(rdoi_pkg::OFS_PINCFG, 32'h0);
      rd_chk(rdoi_pkg::OFS_ALERTEN, 32'h1);
      rd_chk(rdoi_pkg::OFS_TICKDIV, 32'h1);
      rd_chk(8'h1C, 32'h0);
      chk(32'(err), 32'h1);
      // Every mode gets one frame; the buffer only fills in packet modes
      for (int m = 0; m < 5; m++) begin
         wr(rdoi_pkg::OFS_CONTROL, 32'(m));
         rd_chk(rdoi_pkg::OFS_CONTROL, 32'(m));
         frame();
         chk(32'(alert_out_n), (m < 2) ? 32'h0 : 32'h1);
         chk(32'(ps_hi), (m == 1) ? 32'h20 : 32'h0);
         chk(32'(cs_hi), (m == 2) ? 32'h30 : 32'h0);
         chk(32'(any_hi != 0), (m > 0) ? 32'h1 : 32'h0);
         apb(1'b0, rdoi_pkg::OFS_STATUS, 32'h0);
         chk(rd & 32'h11, (m < 2) ? 32'h11 : 32'h0);
         rd_chk(rdoi_pkg::OFS_BUFDATA, (m < 2) ? 32'h0F04 : 32'h0);
         rd_chk(rdoi_pkg::OFS_BUFDATA, 32'h0);
         apb(1'b0, rdoi_pkg::OFS_STATUS, 32'h0);
         chk(rd & 32'h10, 32'h0);
      end
      // A wake-up criterion the mode cannot use keeps the pins silent
      for (int i = 0; i < 3; i++) begin
         wr(rdoi_pkg::OFS_CONTROL, {26'h0, bad_wk[i], 1'b0, bad_md[i]});
         frame();
         chk(32'(any_hi), 32'h0);
      end
      // Alert active high, payload strobe inverted, then alert masked
      wr(rdoi_pkg::OFS_PINCFG, 32'h5);
      @(negedge pclk);
      chk(32'(alert_out_n), 32'h0);
      wr(rdoi_pkg::OFS_CONTROL, 32'h1);
      frame();
      chk(32'(alert_out_n), 32'h1);
      rd_chk(rdoi_pkg::OFS_BUFDATA, 32'h0F04);
      apb(1'b0, rdoi_pkg::OFS_STATUS, 32'h0);
      wr(rdoi_pkg::OFS_ALERTEN, 32'h0);
      frame();
      chk(32'(alert_out_n), 32'h0);
      // Rotation steps the set at each end of reception; set 0 is buffer
      // mode, set 1 payload pin mode, so only the second frame strobes
      wr(rdoi_pkg::OFS_PINCFG, 32'h0);
      wr(rdoi_pkg::OFS_SETCFG, 32'h8);
      rd_chk(rdoi_pkg::OFS_SETCFG, 32'h8);
      wr(rdoi_pkg::OFS_CONTROL, 32'h1000);
      frame();
      chk(32'(active_set), 32'h1);
      chk(32'(ps_hi), 32'h0);
      frame();
      chk(32'(active_set), 32'h2);
      chk(32'(ps_hi), 32'h20);
      tally_and_finish;
   end
endmodule
`default_nettype wire
